// File: src/mvwf_regs.sv
// What this block does
// - busy flag high for a pause frame or for back pressure, one at a time; a pause start during back pressure is ignored.
// - busy flag clears by itself once pause frame transmission completes.
// - first vlan tag id compared with received bytes 13 and 14.
// - second vlan tag id compared with received bytes 13 and 14.
// - tagged frames may be 1522 bytes long, others 1518.
// - first wake port write after reset loads word zero; pointer steps per wake port write.
// - after eighth word the pointer wraps back to word zero.
// - wake filter port is write only.
`include "mvwf_params.svh"

module mvwf_regs (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    // register port
    input  wire mvwf_pkg::mvwf_addr_type addr_i,
    input  wire mvwf_pkg::mvwf_word_type wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output mvwf_pkg::mvwf_word_type     rdata_o,
    // flow control engine
    input  wire logic                   pause_start_i,
    input  wire logic                   pause_done_i,
    input  wire logic                   backpressure_i,
    output logic                        pause_tx_busy_flag_o,
    // receive byte stream
    input  wire logic                   rx_sof_i,
    input  wire logic                   rx_valid_i,
    input  wire logic [7:0]             rx_byte_i,
    input  wire logic                   rx_eof_i,
    output logic                        rx_vlan_tag_one_o,
    output logic                        rx_vlan_tag_two_o,
    output logic                        rx_too_long_o,
    output logic                        rx_frame_done_o,
    // wake filter contents
    output logic [`MVWF_FILTER_WORDS*32-1:0] wake_filter_word_o
);
    import mvwf_pkg::*;

    mvwf_busy_state_type busy_ff;
    logic [15:0]         first_vlan_tag_id_ff;
    logic [15:0]         second_vlan_tag_id_ff;
    logic [10:0]         rx_count_ff;
    logic [7:0]          tag_hi_ff;
    logic                hit1_ff;
    logic                hit2_ff;
    logic                long_ff;
    logic [2:0]          last_stat_ff;
    logic                wake_load;
    mvwf_ptr_type        wake_ptr;
    logic [15:0]         nxt_tag;
    logic [10:0]         nxt_len;
    logic [10:0]         max_len;
    mvwf_word_type       nxt_rdata;

    // busy flag: pause start to pause done, or level back pressure
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= MVWF_BUSY_IDLE;
        end else begin
            case (busy_ff)
                MVWF_BUSY_IDLE: begin
                    if (pause_start_i) begin
                        busy_ff <= MVWF_BUSY_PAUSE;
                    end else if (backpressure_i) begin
                        busy_ff <= MVWF_BUSY_BP;
                    end
                end
                MVWF_BUSY_PAUSE: begin
                    if (pause_done_i) begin
                        busy_ff <= MVWF_BUSY_IDLE;
                    end
                end
                MVWF_BUSY_BP: begin
                    if (!backpressure_i) begin
                        busy_ff <= MVWF_BUSY_IDLE;
                    end
                end
                default: begin
                    busy_ff <= MVWF_BUSY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pause_tx_busy_flag_o <= 1'b0;
        end else begin
            pause_tx_busy_flag_o <= (busy_ff != MVWF_BUSY_IDLE);
        end
    end

    // tag registers; upper bits are reserved and dropped
    // flow control writes are ignored: the busy flag belongs to hardware
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_vlan_tag_id_ff  <= `MVWF_RST_VLAN;
            second_vlan_tag_id_ff <= `MVWF_RST_VLAN;
        end else if (wr_i) begin
            if (addr_i == `MVWF_OFS_VLAN_ONE) begin
                first_vlan_tag_id_ff <= wdata_i[15:0];
            end else if (addr_i == `MVWF_OFS_VLAN_TWO) begin
                second_vlan_tag_id_ff <= wdata_i[15:0];
            end
        end
    end

    // receive tag compare and length check
    assign nxt_tag = {tag_hi_ff, rx_byte_i};
    assign max_len = (hit1_ff || hit2_ff) ? `MVWF_MAX_LEN_VLAN : `MVWF_MAX_LEN_PLAIN;
    assign nxt_len = rx_sof_i ? 11'h001 : rx_count_ff + 11'h001;

    // byte count; the sof byte counts as one
    // count saturates so giant frames never wrap back to legal
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_count_ff <= 11'h000;
        end else if (rx_valid_i && (rx_count_ff != 11'h7ff || rx_sof_i)) begin
            rx_count_ff <= nxt_len;
        end
    end

    // count equals the zero-based position of the arriving byte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tag_hi_ff <= 8'h00;
        end else if (rx_valid_i && !rx_sof_i && rx_count_ff == `MVWF_TAG_BYTE_HI) begin
            tag_hi_ff <= rx_byte_i;
        end
    end

    // tag hits cleared at frame start, judged on the low tag byte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hit1_ff <= 1'b0;
            hit2_ff <= 1'b0;
        end else if (rx_valid_i && rx_sof_i) begin
            hit1_ff <= 1'b0;
            hit2_ff <= 1'b0;
        end else if (rx_valid_i && rx_count_ff == `MVWF_TAG_BYTE_LO) begin
            hit1_ff <= (nxt_tag == first_vlan_tag_id_ff);
            hit2_ff <= (nxt_tag == second_vlan_tag_id_ff);
        end
    end

    // any byte beyond the limit marks the frame too long
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            long_ff <= 1'b0;
        end else if (rx_valid_i && rx_sof_i) begin
            long_ff <= 1'b0;
        end else if (rx_valid_i && rx_count_ff >= max_len) begin
            long_ff <= 1'b1;
        end
    end

    // frame result, held until the next frame ends
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_vlan_tag_one_o    <= 1'b0;
            rx_vlan_tag_two_o    <= 1'b0;
            rx_too_long_o <= 1'b0;
            last_stat_ff  <= 3'h0;
        end else if (rx_eof_i) begin
            rx_vlan_tag_one_o    <= hit1_ff;
            rx_vlan_tag_two_o    <= hit2_ff;
            rx_too_long_o <= long_ff;
            last_stat_ff  <= {long_ff, hit2_ff, hit1_ff};
        end
    end

    // done pulse follows the end marker by one cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_frame_done_o <= 1'b0;
        end else begin
            rx_frame_done_o <= rx_eof_i;
        end
    end

    // wake filter loads on writes only; reads never step the pointer
    assign wake_load = wr_i && (addr_i == `MVWF_OFS_WAKE_PORT);

    mvwf_wake_filter u_wake (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .load_i      (wake_load),
        .load_data_i (wdata_i),
        .words_o     (wake_filter_word_o),
        .ptr_o       (wake_ptr)
    );

    // read mux; the wake port and unmapped indices read as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (!rd_i) begin
            nxt_rdata = 32'h0000_0000;
        end else if (addr_i == `MVWF_OFS_FLOW) begin
            nxt_rdata = {31'h0000_0000, pause_tx_busy_flag_o};
        end else if (addr_i == `MVWF_OFS_VLAN_ONE) begin
            nxt_rdata = {16'h0000, first_vlan_tag_id_ff};
        end else if (addr_i == `MVWF_OFS_VLAN_TWO) begin
            nxt_rdata = {16'h0000, second_vlan_tag_id_ff};
        end else if (addr_i == `MVWF_OFS_FRAME_STAT) begin
            nxt_rdata = {26'h000_0000, wake_ptr, last_stat_ff};
        end else if (addr_i == `MVWF_OFS_WAKE_PORT) begin
            nxt_rdata = 32'h0000_0000;
        end else begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= nxt_rdata;
        end
    end
endmodule : mvwf_regs

// File: src/mvwf_params.svh
`ifndef MVWF_PARAMS_SVH
`define MVWF_PARAMS_SVH

// register offsets (index form)
`define MVWF_OFS_FLOW         4'h8
`define MVWF_OFS_VLAN_ONE     4'h9
`define MVWF_OFS_VLAN_TWO     4'ha
`define MVWF_OFS_WAKE_PORT    4'hb
`define MVWF_OFS_FRAME_STAT   4'he

// reset values
`define MVWF_RST_VLAN         16'h0000
`define MVWF_RST_WORD         32'h0000_0000

// field positions
`define MVWF_BUSY_BIT         0
`define MVWF_STAT_VLAN_TAG_ONE_BIT   0
`define MVWF_STAT_VLAN_TAG_TWO_BIT   1
`define MVWF_STAT_LONG_BIT    2

// frame geometry
`define MVWF_TAG_BYTE_HI      11'h00c
`define MVWF_TAG_BYTE_LO      11'h00d
`define MVWF_MAX_LEN_PLAIN    11'h5ee
`define MVWF_MAX_LEN_VLAN     11'h5f2

// wake filter depth
`define MVWF_FILTER_WORDS     8

`endif

// File: src/mvwf_pkg.sv
`include "mvwf_params.svh"

package mvwf_pkg;
    typedef logic [3:0]  mvwf_addr_type;
    typedef logic [31:0] mvwf_word_type;
    typedef logic [2:0]  mvwf_ptr_type;
    typedef enum logic [1:0] {
        MVWF_BUSY_IDLE  = 2'b00,
        MVWF_BUSY_PAUSE = 2'b01,
        MVWF_BUSY_BP    = 2'b10
    } mvwf_busy_state_type;
endpackage : mvwf_pkg

// File: src/mvwf_wake_filter.sv
`include "mvwf_params.svh"

module mvwf_wake_filter (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // load port
    input  wire logic                  load_i,
    input  wire mvwf_pkg::mvwf_word_type load_data_i,
    // filter contents
    output logic [`MVWF_FILTER_WORDS*32-1:0] words_o,
    output mvwf_pkg::mvwf_ptr_type     ptr_o
);
    import mvwf_pkg::*;

    mvwf_ptr_type ptr_ff;

    // 3-bit pointer wraps 7 -> 0 by itself
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_ff <= 3'h0;
        end else if (load_i) begin
            ptr_ff <= ptr_ff + 3'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MVWF_FILTER_WORDS; gi++) begin : g_word
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    words_o[gi*32 +: 32] <= `MVWF_RST_WORD;
                end else if (load_i && ptr_ff == 3'(gi)) begin
                    words_o[gi*32 +: 32] <= load_data_i;
                end
            end
        end
    endgenerate

    assign ptr_o = ptr_ff;
endmodule : mvwf_wake_filter

// File: bench/mvwf_regs_checker.sv
`include "mvwf_params.svh"
module mvwf_regs_checker (
    // clock, reset and register port
    input wire logic                    clk_i, rst_b_i, wr_i, rd_i,
    input wire mvwf_pkg::mvwf_addr_type addr_i,
    input wire mvwf_pkg::mvwf_word_type wdata_i, rdata_o,
    // flow control, receive, filter
    input wire logic                    pause_start_i, pause_done_i, backpressure_i, pause_tx_busy_flag_o,
    input wire logic                    rx_eof_i, rx_frame_done_o,
    input wire logic [`MVWF_FILTER_WORDS*32-1:0] wake_filter_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mvwf_pkg::*;
    // pointer mirror, reads must not step it
    mvwf_ptr_type wp_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            wp_ff <= 3'h0;
        else if (wr_i && addr_i == 4'hb)
            wp_ff <= wp_ff + 3'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_BUSY_RISE: assert property (pause_start_i && !pause_tx_busy_flag_o && !backpressure_i
        |-> ##2 pause_tx_busy_flag_o) else $error("busy not raised");
    AST_BUSY_FALL: assert property (pause_done_i && pause_tx_busy_flag_o && !backpressure_i
        |-> ##2 !pause_tx_busy_flag_o) else $error("busy not cleared");
    AST_BP_BUSY: assert property (backpressure_i [*2] |=> pause_tx_busy_flag_o)
        else $error("busy low in back pressure");
    AST_WAKE_LOAD: assert property (wr_i && addr_i == 4'hb
        |=> wake_filter_word_o[32*$past(wp_ff)+:32] == $past(wdata_i)) else $error("wake word wrong");
    AST_WAKE_READ: assert property (rd_i && addr_i == 4'hb
        |=> rdata_o == 32'h0 && $stable(wake_filter_word_o)) else $error("wake read not inert");
    AST_TAG_READ: assert property (wr_i && addr_i inside {4'h9, 4'ha}
        ##2 rd_i && addr_i == $past(addr_i, 2) |=> rdata_o == {16'h0, $past(wdata_i[15:0], 3)})
        else $error("tag readback wrong");
    AST_FRAME_DONE: assert property (rx_eof_i |=> rx_frame_done_o)
        else $error("frame result late");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("stray read data");
    cover property (wr_i && addr_i == 4'hb && wp_ff == 3'h7);
    cover property (pause_done_i && pause_tx_busy_flag_o);
    cover property (rx_eof_i);
endmodule : mvwf_regs_checker
bind mvwf_regs mvwf_regs_checker u_chk (.clk_i, .rst_b_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .pause_start_i,
    .pause_done_i, .backpressure_i, .pause_tx_busy_flag_o, .rx_eof_i, .rx_frame_done_o, .wake_filter_word_o);

// File: bench/mvwf_phy_model.sv
module mvwf_phy_model (
    // clock
    input wire logic  clk_i,
    // receive byte stream
    output logic      sof_o, valid_o, eof_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {sof_o, valid_o, eof_o, byte_o} = 11'h000;
    // each idle cycle, eof included, inverts the byte line again, so after an odd gap the eof cycle shows the last byte again
    task automatic frame(input int len, input logic [15:0] tag, input int gap);
        for (int i = 1; i <= len; i++) begin
            @(posedge clk_i) {sof_o, valid_o} <= {i == 1, 1'b1};
            byte_o <= i == 13 ? tag[15:8] : i == 14 ? tag[7:0] : 8'(i);
            repeat (gap) @(posedge clk_i) {sof_o, valid_o, byte_o} <= {2'b00, ~byte_o};
        end
        @(posedge clk_i) {sof_o, valid_o, eof_o, byte_o} <= {3'b001, ~byte_o};
        @(posedge clk_i) eof_o <= 1'b0;
    endtask : frame
endmodule : mvwf_phy_model

// File: bench/mvwf_regs_test.sv
`include "mvwf_params.svh"
module mvwf_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mvwf_pkg::*;
    logic          clk_i, rst_b_i, wr_i, rd_i, pause_start_i, pause_done_i, backpressure_i;
    logic          sof, vld, eof, busy, v1, v2, lng, done;
    logic [7:0]    rxb;
    logic [255:0]  words;
    mvwf_addr_type addr_i;
    mvwf_word_type wdata_i, rdata_o, q;
    int            n_mismatch, comparisons;
    mvwf_regs dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pause_start_i, .pause_done_i,
        .backpressure_i, .pause_tx_busy_flag_o(busy), .rx_sof_i(sof), .rx_valid_i(vld), .rx_byte_i(rxb),
        .rx_eof_i(eof), .rx_vlan_tag_one_o(v1), .rx_vlan_tag_two_o(v2), .rx_too_long_o(lng), .rx_frame_done_o(done),
        .wake_filter_word_o(words));
    mvwf_phy_model phy (.clk_i, .sof_o(sof), .valid_o(vld), .eof_o(eof), .byte_o(rxb));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input mvwf_word_type exp, input mvwf_word_type got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input mvwf_addr_type a, input mvwf_word_type d);
        @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input mvwf_addr_type a);
        @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i) rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask : rd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic t_busy;
        @(posedge clk_i) pause_start_i <= 1'b1;
        @(posedge clk_i) pause_start_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk("busy pause", 32'h1, 32'(busy));
        rd(4'h8);
        chk("busy bit", 32'h1, q);
        @(posedge clk_i) pause_done_i <= 1'b1;
        @(posedge clk_i) pause_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk("busy done", 32'h0, 32'(busy));
        @(posedge clk_i) backpressure_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk("busy bp", 32'h1, 32'(busy));
        @(posedge clk_i) backpressure_i <= 1'b0;
        for (int n = 0; n < 8 && q[0] !== 1'b0; n++)
            rd(4'h8);
        chk("busy polled", 32'h0, q);
        if (q[0] !== 1'b0)
            conclude();
        wr(4'h8, 32'hffff_fffe);
        rd(4'h8);
        chk("flow after write", 32'h0, q);
        $display("busy test done");
    endtask : t_busy
    task automatic t_wake;
        for (int i = 0; i < 10; i++) begin
            wr(4'hb, 32'hc0de_0000 + 32'(i));
            if (i == 4)
                rd(4'hb);
        end
        #1 chk("wake read", 32'h0, q);
        for (int k = 0; k < 8; k++)
            chk("wake word", 32'hc0de_0000 + 32'(k < 2 ? k + 8 : k), words[32*k+:32]);
        $display("wake test done");
    endtask : t_wake
    task automatic t_rx;
        logic [15:0] t1[5] = '{16'h8100, 16'h8100, 16'h0000, 16'h0000, 16'h0000};
        logic [15:0] tf[5] = '{16'h8100, 16'h0800, 16'h8100, 16'h0800, 16'h8100};
        int          len[5] = '{1522, 1519, 1523, 1518, 60};
        logic [2:0]  ex[5] = '{3'b001, 3'b100, 3'b110, 3'b000, 3'b010};
        for (int i = 0; i < 5; i++) begin
            wr(4'h9, {16'hffff, t1[i]});
            rd(4'h9);
            chk("tag one", {16'h0, t1[i]}, q);
            wr(4'ha, {16'hffff, t1[i] ^ 16'h8100});
            rd(4'ha);
            chk("tag two", {16'h0, t1[i] ^ 16'h8100}, q);
            phy.frame(len[i], tf[i], i % 2);
            #1 chk("frame flags", 32'({1'b1, ex[i]}), 32'({done, lng, v2, v1}));
            rd(4'he);
            chk("frame stat", 32'({3'h2, ex[i]}), q);
        end
        $display("rx test done");
    endtask : t_rx
    task automatic t_reset;
        @(posedge clk_i) rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wr(4'hb, 32'h5a5a_0001);
        #1 chk("wake word zero", 32'h5a5a_0001, words[31:0]);
        chk("wake word one", 32'h0, words[63:32]);
        rd(4'h9);
        chk("tag one reset", 32'h0, q);
        rd(4'he);
        chk("stat reset", 32'h0000_0008, q);
        $display("reset test done");
    endtask : t_reset
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        {rst_b_i, wr_i, rd_i, pause_start_i, pause_done_i, backpressure_i} = 6'h00;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
            chk("reset read", 32'h0, q);
        end
        t_busy();
        t_wake();
        t_rx();
        t_reset();
        conclude();
    end
endmodule : mvwf_regs_test
